// ### verilog/adc_seq_pkg.sv
`default_nettype none
package adc_seq_pkg;
  localparam int unsigned ADDR_W        = 8;
  localparam int unsigned DATA_W        = 32;
  localparam int unsigned RESULT_W      = 12;
  localparam int unsigned CHAN_W        = 4;
  localparam int unsigned NUM_CHANNELS  = 16;

  // Register byte offsets
  localparam logic [7:0] OFF_CONTROL_ONE   = 8'h00;
  localparam logic [7:0] OFF_CONTROL_THREE = 8'h04;
  localparam logic [7:0] OFF_CHANNEL       = 8'h08;
  localparam logic [7:0] OFF_TRIGGER       = 8'h0C;
  localparam logic [7:0] OFF_INT_STATUS    = 8'h10;
  localparam logic [7:0] OFF_INT_MASK      = 8'h14;
  localparam logic [7:0] OFF_LIVE_STATUS   = 8'h18;
  localparam logic [7:0] OFF_RESULT_BASE   = 8'h40;
  localparam logic [7:0] OFF_RESULT_MASK   = 8'hC0;

  // converter_control_one fields
  localparam int unsigned DUAL_SAMPLE_BIT = 0;
  localparam int unsigned CONTINUOUS_BIT  = 1;
  localparam int unsigned ACQ_LSB         = 8;
  localparam int unsigned ACQ_W           = 4;
  // converter_control_three fields
  localparam int unsigned BANDGAP_HI_BIT  = 7;
  localparam int unsigned BANDGAP_LO_BIT  = 6;
  localparam int unsigned CORE_POWER_BIT  = 5;
  localparam int unsigned CLKDIV_LSB      = 0;
  localparam int unsigned CLKDIV_W        = 4;
  // trigger register fields
  localparam int unsigned SW_START_BIT    = 0;
  localparam int unsigned SW_STOP_BIT     = 1;
  localparam int unsigned EVA_EN_BIT      = 4;
  localparam int unsigned EVB_EN_BIT      = 5;
  localparam int unsigned EXT_EN_BIT      = 6;
  // interrupt fields
  localparam int unsigned INT_W           = 2;
  localparam int unsigned INT_RESULT_BIT  = 0;
  localparam int unsigned INT_OVERRUN_BIT = 1;

  // Reset values
  localparam logic [31:0] RST_CONTROL_ONE   = 32'h0000_0000;
  localparam logic [31:0] RST_CONTROL_THREE = 32'h0000_0000;
  localparam logic [31:0] RST_CHANNEL       = 32'h0000_0000;
  localparam logic [31:0] RST_TRIGGER       = 32'h0000_0000;
  localparam logic [INT_W-1:0] RST_INT_MASK = 2'h0;

  // Timing in converter half periods and system clocks
  localparam int unsigned START_DELAY_HALVES = 5;
  localparam int unsigned PIPE_STAGES        = 4;
  localparam int unsigned IRQ_LAG_CYCLES     = 2;
  localparam int unsigned HALF_CNT_W         = 6;

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_DELAY, SEQ_HOLD, SEQ_GAP} seq_state_t;

  // Sample/hold high time in converter half periods
  function automatic logic [HALF_CNT_W-1:0] hold_halves(input logic [ACQ_W-1:0] acq);
    hold_halves = {({1'b0, acq} + 5'h01), 1'b0};
  endfunction

  // Channel of the analog side for one half of a pair
  function automatic logic [CHAN_W-1:0] pair_channel(input logic [CHAN_W-1:0] sel,
                                                     input logic upper);
    pair_channel = {upper, sel[CHAN_W-2:0]};
  endfunction
endpackage
`default_nettype wire

// ### verilog/adc_result_mem.sv
`default_nettype none
module adc_result_mem
  import adc_seq_pkg::*;
(
  input  wire logic                ref_clk,
  input  wire logic                writeEn,
  input  wire logic [CHAN_W-1:0]   writeAddr,
  input  wire logic [RESULT_W-1:0] writeData,
  input  wire logic [CHAN_W-1:0]   readAddr,
  output logic      [RESULT_W-1:0] readData
);
  logic [RESULT_W-1:0] store [NUM_CHANNELS];

  always_ff @(posedge ref_clk) begin
    if (writeEn) begin
      store[writeAddr] <= writeData;
    end
  end

  always_ff @(posedge ref_clk) begin
    readData <= store[readAddr];
  end
endmodule // adc_result_mem
`default_nettype wire

// ### verilog/adc_clock_divider.sv
`default_nettype none
module adc_clock_divider
  import adc_seq_pkg::*;
(
  input  wire logic                ref_clk,
  input  wire logic                resetn,
  input  wire logic                restart,
  input  wire logic [CLKDIV_W-1:0] divide,
  output logic                     halfTick,
  output logic                     periodTick
);
  logic [CLKDIV_W-1:0] count_reg;
  logic                phase_reg;
  logic                wrap;

  assign wrap = (count_reg == divide);

  // One half converter period is divide+1 system clocks
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      count_reg <= '0;
    end else if (restart || wrap) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_reg + 4'h1;
    end
  end

  // Odd half ticks after a restart are converter period edges
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      phase_reg  <= 1'b0;
      halfTick   <= 1'b0;
      periodTick <= 1'b0;
    end else begin
      halfTick   <= wrap && !restart;
      periodTick <= wrap && !restart && !phase_reg;
      if (restart) begin
        phase_reg <= 1'b0;
      end else if (wrap) begin
        phase_reg <= !phase_reg;
      end
    end
  end
endmodule // adc_clock_divider
`default_nettype wire

// ### verilog/adc_sequencing_control.sv
// Operation
// - All three power bits clear together
// - Sixteen channels, one or two sampled
// - Twelve-bit result through four-stage pipeline
// - Mode bit: zero single, one dual
// - Start by events, software or pin
// - Sequential: one conversion per hold pulse
// - Channel captured at hold pulse fall
// - Interrupt flags lag result update slightly
// - Hold width is acquisition plus one
// - Sampling starts 2.5 periods after trigger
// - First result four periods after sampling
// - Later results every acquisition plus two
//
// The APB interface to the registers and the placing of the registers were decided locally.
`default_nettype none
module adc_sequencing_control
  import adc_seq_pkg::*;
(
  input  wire logic                        ref_clk,
  input  wire logic                        resetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [adc_seq_pkg::ADDR_W-1:0]   paddr,
  input  wire logic [adc_seq_pkg::DATA_W-1:0]   pwdata,
  output logic      [adc_seq_pkg::DATA_W-1:0]   prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic                        eventTriggerA,
  input  wire logic                        eventTriggerB,
  input  wire logic                        externalStart,
  input  wire logic [adc_seq_pkg::RESULT_W-1:0] sampleCodeA,
  input  wire logic [adc_seq_pkg::RESULT_W-1:0] sampleCodeB,
  output logic                             sampleHold,
  output logic      [adc_seq_pkg::CHAN_W-1:0]   channelA,
  output logic      [adc_seq_pkg::CHAN_W-1:0]   channelB,
  output logic                             bandgapReferenceOn,
  output logic                             coreConverterOn,
  output logic                             irq
);
  logic [31:0]             control_one_reg;
  logic [31:0]             control_three_reg;
  logic [31:0]             channel_reg;
  logic [31:0]             trigger_reg;
  logic [INT_W-1:0]        intStatus_reg;
  logic [INT_W-1:0]        intMask_reg;
  seq_state_t              state_reg;
  logic [HALF_CNT_W-1:0]   halfCount_reg;
  logic                    extPrev_reg;
  logic [PIPE_STAGES-1:0]  pipeValid_reg;
  logic [RESULT_W-1:0]     pipeA_reg [PIPE_STAGES];
  logic [RESULT_W-1:0]     pipeB_reg [PIPE_STAGES];
  logic [CHAN_W-1:0]       pipeChan_reg [PIPE_STAGES];
  logic [PIPE_STAGES-1:0]  pipeDual_reg;
  logic                    pendingB_reg;
  logic [RESULT_W-1:0]     pendingData_reg;
  logic [CHAN_W-1:0]       pendingChan_reg;
  logic [IRQ_LAG_CYCLES-1:0] doneLag_reg;

  logic                    access;
  logic                    wrEn;
  logic                    rdEn;
  logic                    isResult;
  logic                    mapped;
  logic                    swStart;
  logic                    swStop;
  logic                    powerReady;
  logic                    trigger;
  logic                    halfTick;
  logic                    periodTick;
  logic                    holdFall;
  logic                    dualMode;
  logic [ACQ_W-1:0]        acqWindow;
  logic                    memWrEn;
  logic [CHAN_W-1:0]       memWrAddr;
  logic [RESULT_W-1:0]     memWrData;
  logic [RESULT_W-1:0]     memRdData;
  logic                    overrun;
  logic [31:0]             readMux;

  assign access    = psel && penable && !pready;
  assign wrEn      = access && pwrite;
  assign rdEn      = access && !pwrite;
  assign isResult  = ((paddr & OFF_RESULT_MASK) == OFF_RESULT_BASE);
  assign mapped    = isResult || (paddr == OFF_CONTROL_ONE) || (paddr == OFF_CONTROL_THREE)
                     || (paddr == OFF_CHANNEL) || (paddr == OFF_TRIGGER)
                     || (paddr == OFF_INT_STATUS) || (paddr == OFF_INT_MASK)
                     || (paddr == OFF_LIVE_STATUS);
  assign swStart   = wrEn && (paddr == OFF_TRIGGER) && pwdata[SW_START_BIT];
  assign swStop    = wrEn && (paddr == OFF_TRIGGER) && pwdata[SW_STOP_BIT];
  assign dualMode  = control_one_reg[DUAL_SAMPLE_BIT];
  assign acqWindow = control_one_reg[ACQ_LSB +: ACQ_W];

  // Settling delays are software's duty; the block refuses starts and returns the sequencer to idle while unpowered
  assign powerReady = control_three_reg[BANDGAP_HI_BIT] && control_three_reg[BANDGAP_LO_BIT]
                      && control_three_reg[CORE_POWER_BIT];

  assign trigger = powerReady && (swStart
                   || (eventTriggerA && trigger_reg[EVA_EN_BIT])
                   || (eventTriggerB && trigger_reg[EVB_EN_BIT])
                   || (externalStart && !extPrev_reg && trigger_reg[EXT_EN_BIT]));

  assign holdFall = (state_reg == SEQ_HOLD) && halfTick && (halfCount_reg == 6'h01);
  assign overrun  = trigger && (state_reg != SEQ_IDLE);

  adc_clock_divider divider (
    .ref_clk    (ref_clk),
    .resetn     (resetn),
    .restart    (trigger && (state_reg == SEQ_IDLE)),
    .divide     (control_three_reg[CLKDIV_LSB +: CLKDIV_W]),
    .halfTick   (halfTick),
    .periodTick (periodTick)
  );

  // Register writes; power bits take any combination in one write
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      control_one_reg   <= RST_CONTROL_ONE;
      control_three_reg <= RST_CONTROL_THREE;
      channel_reg       <= RST_CHANNEL;
      trigger_reg       <= RST_TRIGGER;
      intMask_reg       <= RST_INT_MASK;
    end else if (wrEn) begin
      unique case (paddr)
        OFF_CONTROL_ONE:   control_one_reg   <= pwdata;
        OFF_CONTROL_THREE: control_three_reg <= pwdata;
        OFF_CHANNEL:       channel_reg       <= pwdata;
        OFF_TRIGGER:       trigger_reg       <= pwdata & 32'h0000_00F0;
        OFF_INT_MASK:      intMask_reg       <= pwdata[INT_W-1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      extPrev_reg <= 1'b0;
    end else begin
      extPrev_reg <= externalStart;
    end
  end

  // Sequencer in converter half periods
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg     <= SEQ_IDLE;
      halfCount_reg <= '0;
    end else if (!powerReady || swStop) begin
      state_reg     <= SEQ_IDLE;
      halfCount_reg <= '0;
    end else begin
      unique case (state_reg)
        SEQ_IDLE: begin
          if (trigger) begin
            state_reg     <= SEQ_DELAY;
            halfCount_reg <= HALF_CNT_W'(START_DELAY_HALVES);
          end
        end
        SEQ_DELAY: begin
          if (halfTick) begin
            if (halfCount_reg == 6'h01) begin
              state_reg     <= SEQ_HOLD;
              halfCount_reg <= hold_halves(acqWindow);
            end else begin
              halfCount_reg <= halfCount_reg - 6'h01;
            end
          end
        end
        SEQ_HOLD: begin
          if (halfTick) begin
            if (halfCount_reg == 6'h01) begin
              state_reg     <= control_one_reg[CONTINUOUS_BIT] ? SEQ_GAP : SEQ_IDLE;
              halfCount_reg <= 6'h02;
            end else begin
              halfCount_reg <= halfCount_reg - 6'h01;
            end
          end
        end
        SEQ_GAP: begin
          if (halfTick) begin
            if (halfCount_reg == 6'h01) begin
              state_reg     <= SEQ_HOLD;
              halfCount_reg <= hold_halves(acqWindow);
            end else begin
              halfCount_reg <= halfCount_reg - 6'h01;
            end
          end
        end
      endcase
    end
  end

  // Analog side drive
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sampleHold         <= 1'b0;
      channelA           <= '0;
      channelB           <= '0;
      bandgapReferenceOn <= 1'b0;
      coreConverterOn    <= 1'b0;
    end else begin
      sampleHold <= powerReady && !swStop && (((state_reg == SEQ_HOLD) && !holdFall)
                    || (((state_reg == SEQ_DELAY) || (state_reg == SEQ_GAP)) && halfTick
                        && (halfCount_reg == 6'h01)));
      channelA   <= dualMode ? pair_channel(channel_reg[CHAN_W-1:0], 1'b0)
                             : channel_reg[CHAN_W-1:0];
      channelB   <= pair_channel(channel_reg[CHAN_W-1:0], 1'b1);
      bandgapReferenceOn <= control_three_reg[BANDGAP_HI_BIT] && control_three_reg[BANDGAP_LO_BIT];
      coreConverterOn    <= control_three_reg[CORE_POWER_BIT];
    end
  end

  // Four-stage conversion pipeline stepped by converter periods
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pipeValid_reg <= '0;
      pipeDual_reg  <= '0;
      for (int i = 0; i < PIPE_STAGES; i++) begin
        pipeA_reg[i]    <= '0;
        pipeB_reg[i]    <= '0;
        pipeChan_reg[i] <= '0;
      end
    end else begin
      if (periodTick) begin
        for (int i = 1; i < PIPE_STAGES; i++) begin
          pipeValid_reg[i] <= pipeValid_reg[i-1];
          pipeDual_reg[i]  <= pipeDual_reg[i-1];
          pipeA_reg[i]     <= pipeA_reg[i-1];
          pipeB_reg[i]     <= pipeB_reg[i-1];
          pipeChan_reg[i]  <= pipeChan_reg[i-1];
        end
        pipeValid_reg[0] <= 1'b0;
      end
      if (holdFall) begin
        pipeValid_reg[0] <= 1'b1;
        pipeDual_reg[0]  <= dualMode;
        pipeA_reg[0]     <= sampleCodeA;
        pipeB_reg[0]     <= sampleCodeB;
        pipeChan_reg[0]  <= channelA;
      end
    end
  end

  // Result write: fourth period after the fall; dual B follows one clock later
  assign memWrEn   = (periodTick && pipeValid_reg[PIPE_STAGES-1]) || pendingB_reg;
  assign memWrAddr = pendingB_reg ? pendingChan_reg : pipeChan_reg[PIPE_STAGES-1];
  assign memWrData = pendingB_reg ? pendingData_reg : pipeA_reg[PIPE_STAGES-1];

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pendingB_reg    <= 1'b0;
      pendingData_reg <= '0;
      pendingChan_reg <= '0;
    end else begin
      pendingB_reg    <= periodTick && pipeValid_reg[PIPE_STAGES-1]
                         && pipeDual_reg[PIPE_STAGES-1];
      pendingData_reg <= pipeB_reg[PIPE_STAGES-1];
      pendingChan_reg <= pair_channel(pipeChan_reg[PIPE_STAGES-1], 1'b1);
    end
  end

  adc_result_mem results (
    .ref_clk   (ref_clk),
    .writeEn   (memWrEn),
    .writeAddr (memWrAddr),
    .writeData (memWrData),
    .readAddr  (paddr[CHAN_W+1:2]),
    .readData  (memRdData)
  );

  // Interrupt lags the result update by a few clocks
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      doneLag_reg <= '0;
    end else begin
      doneLag_reg <= {doneLag_reg[IRQ_LAG_CYCLES-2:0], memWrEn && !pendingB_reg};
    end
  end

  // Sticky flags, set wins over write-one-to-clear
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      intStatus_reg <= '0;
    end else begin
      for (int i = 0; i < INT_W; i++) begin
        if ((i == INT_RESULT_BIT && doneLag_reg[IRQ_LAG_CYCLES-1])
            || (i == INT_OVERRUN_BIT && overrun)) begin
          intStatus_reg[i] <= 1'b1;
        end else if (wrEn && (paddr == OFF_INT_STATUS) && pwdata[i]) begin
          intStatus_reg[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(intStatus_reg & intMask_reg);
    end
  end

  always_comb begin
    readMux = 32'h0000_0000;
    unique case (paddr)
      OFF_CONTROL_ONE:   readMux = control_one_reg;
      OFF_CONTROL_THREE: readMux = control_three_reg;
      OFF_CHANNEL:       readMux = channel_reg;
      OFF_TRIGGER:       readMux = trigger_reg;
      OFF_INT_STATUS:    readMux = {30'h0, intStatus_reg};
      OFF_INT_MASK:      readMux = {30'h0, intMask_reg};
      OFF_LIVE_STATUS:   readMux = {28'h0, sampleHold, powerReady, state_reg};
      default:           readMux = isResult ? {20'h0, memRdData} : 32'h0000_0000;
    endcase
  end

  // APB answer on the second access cycle
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= access;
      pslverr <= access && !mapped;
      if (rdEn) begin
        prdata <= mapped ? readMux : 32'h0000_0000;
      end
    end
  end
endmodule // adc_sequencing_control
`default_nettype wire

// ### test/adc_sequencing_control_checker.sv
`default_nettype none
module adc_sequencing_control_checker (
  input wire logic                            ref_clk,
  input wire logic                            resetn,
  input wire logic                            psel,
  input wire logic                            penable,
  input wire logic                            pwrite,
  input wire logic [adc_seq_pkg::ADDR_W-1:0]  paddr,
  input wire logic [adc_seq_pkg::DATA_W-1:0]  pwdata,
  input wire logic [adc_seq_pkg::DATA_W-1:0]  prdata,
  input wire logic                            pready,
  input wire logic                            pslverr,
  input wire logic                            sampleHold,
  input wire logic [adc_seq_pkg::CHAN_W-1:0]  channelA,
  input wire logic [adc_seq_pkg::CHAN_W-1:0]  channelB,
  input wire logic                            bandgapReferenceOn,
  input wire logic                            coreConverterOn
);
  timeunit 1ns;
  timeprecision 1ps;
  import adc_seq_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  logic       wr;
  logic       dual;
  logic       cont;
  logic       seen;
  logic [3:0] acq;
  logic [3:0] div;
  logic [9:0] hiCnt;
  logic [9:0] loCnt;
  assign wr = psel && penable && pready && pwrite;
  // Shadow of the timing fields
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      {div, acq, cont, dual} <= '0;
    end else if (wr && paddr == OFF_CONTROL_ONE) begin
      {acq, cont, dual} <= {pwdata[11:8], pwdata[1:0]};
    end else if (wr && paddr == OFF_CONTROL_THREE) begin
      div <= pwdata[3:0];
    end
  end
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      hiCnt <= '0;
      loCnt <= '0;
    end else begin
      hiCnt <= sampleHold ? hiCnt + 10'h001 : 10'h000;
      loCnt <= sampleHold ? 10'h000 : loCnt + {9'h000, loCnt != 10'h3FF};
    end
  end
  // Gap is only meaningful after a pulse of the same run
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      seen <= 1'b0;
    end else if (wr && (paddr == OFF_TRIGGER || paddr == OFF_CONTROL_ONE)) begin
      seen <= 1'b0;
    end else if (!sampleHold && hiCnt != 10'h000) begin
      seen <= 1'b1;
    end
  end
  property p_ready; psel && penable && !pready |=> pready; endproperty
  a_ready: assert property (p_ready) else $error("pready missing");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("pready too long");
  property p_err; pready && pslverr && !pwrite |-> prdata == '0; endproperty
  a_err: assert property (p_err) else $error("refused read not zero");
  property p_bg;
    wr && paddr == OFF_CONTROL_THREE |=> bandgapReferenceOn == ($past(pwdata[7]) && $past(pwdata[6]));
  endproperty
  a_bg: assert property (p_bg) else $error("reference output wrong");
  property p_core; wr && paddr == OFF_CONTROL_THREE |=> coreConverterOn == $past(pwdata[5]); endproperty
  a_core: assert property (p_core) else $error("core output wrong");
  property p_pwr; $rose(sampleHold) |-> bandgapReferenceOn && coreConverterOn; endproperty
  a_pwr: assert property (p_pwr) else $error("sampling while unpowered");
  property p_width;
    $fell(sampleHold) && !(wr && paddr == OFF_TRIGGER && pwdata[SW_STOP_BIT])
      |-> hiCnt == 2 * (acq + 1) * (div + 1);
  endproperty
  a_width: assert property (p_width) else $error("hold width wrong");
  property p_gap; $rose(sampleHold) && seen && cont |-> loCnt == 2 * (div + 1); endproperty
  a_gap: assert property (p_gap) else $error("pulse spacing wrong");
  property p_dual; sampleHold && dual |-> channelA == {1'b0, channelB[2:0]} && channelB[3]; endproperty
  a_dual: assert property (p_dual) else $error("channel pair wrong");
  property p_seq; sampleHold && $past(sampleHold) && !dual |-> $stable(channelA); endproperty
  a_seq: assert property (p_seq) else $error("channel moved in pulse");
  c_dual: cover property (sampleHold && dual);
  c_gap: cover property ($rose(sampleHold) && seen && cont);
  c_err: cover property (pready && pslverr);
endmodule // adc_sequencing_control_checker
`default_nettype wire

// ### test/adc_analog_model.sv
`default_nettype none
module adc_analog_model (
  input  wire logic [adc_seq_pkg::CHAN_W-1:0]   channelA,
  input  wire logic [adc_seq_pkg::CHAN_W-1:0]   channelB,
  input  wire logic                             sampleHold,
  output logic      [adc_seq_pkg::RESULT_W-1:0] sampleCodeA,
  output logic      [adc_seq_pkg::RESULT_W-1:0] sampleCodeB
);
  timeunit 1ns;
  timeprecision 1ps;
  import adc_seq_pkg::*;
  // Code valid only while held, inverted otherwise
  assign sampleCodeA = sampleHold ? {channelA, 8'h5A} : ~{channelA, 8'h5A};
  assign sampleCodeB = sampleHold ? {channelB, 8'h5A} : ~{channelB, 8'h5A};
endmodule // adc_analog_model
`default_nettype wire

// ### test/test_adc_sequencing_control.sv
`default_nettype none
module test_adc_sequencing_control;
  timeunit 1ns;
  timeprecision 1ps;
  import adc_seq_pkg::*;
  logic                ref_clk = 1'b0;
  logic                resetn = 1'b0;
  logic                psel = 1'b0;
  logic                penable = 1'b0;
  logic                pwrite = 1'b0;
  logic [ADDR_W-1:0]   paddr = '0;
  logic [DATA_W-1:0]   pwdata = '0;
  logic [2:0]          pins = '0;
  logic [DATA_W-1:0]   prdata, rd;
  logic                pready, pslverr, er, sampleHold, irq, bgOn, coreOn;
  logic                shPrev = 1'b0, irqPrev = 1'b0;
  logic [CHAN_W-1:0]   channelA, channelB;
  logic [RESULT_W-1:0] sampleCodeA, sampleCodeB;
  int                  cyc = 0, tRise = 0, tFall = 0, tIrq = 0, width = 0, period = 0;
  int                  nRise = 0, nFail = 0, cmpCount = 0;
  // Cases: dual, acq, divide, channel; trigger source is index modulo 4
  logic [15:0]         tbl [5] = '{16'h0005, 16'h0F03, 16'h1212, 16'h012F, 16'h1007};
  adc_sequencing_control adc_sequencing_control_inst (
    .ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .eventTriggerA(pins[0]), .eventTriggerB(pins[1]), .externalStart(pins[2]),
    .sampleCodeA(sampleCodeA), .sampleCodeB(sampleCodeB), .sampleHold(sampleHold),
    .channelA(channelA), .channelB(channelB), .bandgapReferenceOn(bgOn),
    .coreConverterOn(coreOn), .irq(irq));
  adc_analog_model adc_analog_model_inst (.channelA(channelA), .channelB(channelB),
    .sampleHold(sampleHold), .sampleCodeA(sampleCodeA), .sampleCodeB(sampleCodeB));
  always #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    shPrev <= sampleHold;
    irqPrev <= irq;
    if (sampleHold && !shPrev) begin
      period <= cyc - tRise;
      tRise <= cyc;
      nRise <= nRise + 1;
    end
    if (!sampleHold && shPrev) begin
      width <= cyc - tRise;
      tFall <= cyc;
    end
    if (irq && !irqPrev) tIrq <= cyc;
  end
  task automatic closeOut();
    $display("compares %0d mismatches %0d", cmpCount, nFail);
    if (nFail == 0 && cmpCount > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      nFail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, rd, e);
  endtask
  task automatic runOne(input int i);
    logic [3:0] acq, div, ch, a;
    logic       dual;
    int         h, tTrig;
    {dual, acq, div, ch} = {tbl[i][12], tbl[i][11:0]};
    h = div + 1;
    a = dual ? {1'b0, ch[2:0]} : ch;
    apb(1'b1, OFF_CONTROL_ONE, {20'h0, acq, 7'h0, dual});
    apb(1'b1, OFF_CONTROL_THREE, {24'h0, 4'hE, div});
    apb(1'b1, OFF_CHANNEL, {28'h0, ch});
    apb(1'b1, OFF_INT_STATUS, 32'h0000_0003);
    apb(1'b1, OFF_INT_MASK, 32'h0000_0001);
    if (i % 4 == 0) begin
      apb(1'b1, OFF_TRIGGER, 32'h0000_0071);
      tTrig = cyc - 1;
    end else begin
      @(posedge ref_clk);
      pins <= 3'b001 << (i % 4 - 1);
      tTrig = cyc + 1;
      @(posedge ref_clk);
      pins <= 3'b000;
    end
    for (int k = 0; k < 600 && irq !== 1'b1; k++) @(posedge ref_clk);
    @(posedge ref_clk);
    chk("irq", irq, 1'b1);
    chk("start", (tRise - tTrig) inside {[5 * h - 1:5 * h + 4]}, 1'b1);
    chk("width", width, 2 * (acq + 1) * h);
    chk("latency", (tIrq - tFall) inside {[8 * h + 1:8 * h + 5]}, 1'b1);
    rchk("resA", OFF_RESULT_BASE + {2'b00, a, 2'b00}, {20'h0, a, 8'h5A});
    if (dual) rchk("resB", OFF_RESULT_BASE + {2'b00, a | 4'h8, 2'b00}, {20'h0, a | 4'h8, 8'h5A});
    rchk("status", OFF_INT_STATUS, 32'h0000_0001);
    apb(1'b1, OFF_INT_STATUS, 32'h0000_0001);
    repeat (2) @(posedge ref_clk);
    chk("irqClr", irq, 1'b0);
  endtask
  initial begin
    int base;
    repeat (12) @(posedge ref_clk);
    resetn <= 1'b1;
    chk("outs", {sampleHold, bgOn, coreOn, irq}, 4'h0);
    for (int k = 0; k < 6; k++) rchk("reset", 8'(4 * k), 32'h0);
    rchk("unmapped", 8'h3C, 32'h0);
    chk("rdErr", er, 1'b1);
    apb(1'b1, OFF_TRIGGER, 32'h0000_0071);
    repeat (60) @(posedge ref_clk);
    chk("gated", nRise, 0);
    apb(1'b1, OFF_CONTROL_THREE, 32'h0000_00C0);
    @(posedge ref_clk);
    chk("bgOnly", {bgOn, coreOn}, 2'b10);
    apb(1'b1, OFF_CONTROL_THREE, 32'h0000_00E0);
    @(posedge ref_clk);
    chk("allOn", {bgOn, coreOn}, 2'b11);
    apb(1'b1, OFF_CONTROL_THREE, 32'h0000_0000);
    @(posedge ref_clk);
    chk("allOff", {bgOn, coreOn}, 2'b00);
    for (int i = 0; i < 5; i++) runOne(i);
    apb(1'b1, OFF_CONTROL_ONE, 32'h0000_0102);
    apb(1'b1, OFF_CONTROL_THREE, 32'h0000_00E1);
    apb(1'b1, OFF_INT_MASK, 32'h0000_0000);
    apb(1'b1, OFF_TRIGGER, 32'h0000_0071);
    base = nRise;
    for (int k = 0; k < 600 && nRise < base + 3; k++) @(posedge ref_clk);
    @(posedge ref_clk);
    chk("period", period, 12);
    chk("widthC", width, 8);
    apb(1'b1, OFF_TRIGGER, 32'h0000_0071);
    rchk("overrun", OFF_INT_STATUS, 32'h0000_0003);
    chk("masked", irq, 1'b0);
    apb(1'b1, OFF_INT_MASK, 32'h0000_0003);
    repeat (2) @(posedge ref_clk);
    chk("unmasked", irq, 1'b1);
    apb(1'b1, OFF_TRIGGER, 32'h0000_0072);
    repeat (40) @(posedge ref_clk);
    apb(1'b1, OFF_INT_STATUS, 32'h0000_0003);
    repeat (2) @(posedge ref_clk);
    chk("cleared", irq, 1'b0);
    rchk("idle", OFF_LIVE_STATUS, 32'h0000_0004);
    closeOut();
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    nFail++;
    $display("[FAIL] watchdog expected end seen hang");
    closeOut();
  end
endmodule // test_adc_sequencing_control
bind adc_sequencing_control adc_sequencing_control_checker adc_sequencing_control_checker_inst (
  .ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .sampleHold(sampleHold), .channelA(channelA), .channelB(channelB),
  .bandgapReferenceOn(bandgapReferenceOn), .coreConverterOn(coreConverterOn));
`default_nettype wire
